// ### core/iifr_defines.vh
`ifndef IIFR_DEFINES_VH
`define IIFR_DEFINES_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define IIFR_ADDR_W          8
`define IIFR_OFF_TX_EVT_SET  8'h90
`define IIFR_OFF_TX_EVT_CLR  8'h94
`define IIFR_OFF_TX_MSK_SET  8'h98
`define IIFR_OFF_TX_MSK_CLR  8'h9c
`define IIFR_OFF_RX_EVT_SET  8'ha0
`define IIFR_OFF_RX_EVT_CLR  8'ha4
`define IIFR_OFF_RX_MSK_SET  8'ha8
`define IIFR_OFF_RX_MSK_CLR  8'hac
`define IIFR_OFF_FAIRNESS    8'hdc
`define IIFR_OFF_MAIN_MSK    8'hf0
// ---------------------------------------------------------------
// field widths and reset values
// ---------------------------------------------------------------
`define IIFR_TX_CH           8
`define IIFR_RX_CH           4
`define IIFR_PRI_W           8
`define IIFR_TX_RST          8'h00
`define IIFR_RX_RST          4'h0
`define IIFR_PRI_RST         8'h00
`define IIFR_GATE_BIT        31
`define IIFR_ZERO32          32'h00000000
`endif

// ### core/iifr_event_bits.v
`default_nettype none
`include "iifr_defines.vh"
// sticky event bits: set by rising edge or software, cleared by software only
module iifr_event_bits #(
    parameter N = 4
) (
    input  wire         core_clk_i,
    input  wire         rst_b_i,
    input  wire [N-1:0] ctx_irq_i,
    input  wire [N-1:0] sw_set_i,
    input  wire [N-1:0] sw_clr_i,
    output reg  [N-1:0] event_o
);
    reg [N-1:0] irq_prev_q;    // last sample of context lines
    wire [N-1:0] rise;         // asserting edge per context

    assign rise = ctx_irq_i & ~irq_prev_q;

    // ---------------------------------------------------------------
    // per-bit sticky flops
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1)
        begin : g_bit
            // edge detect and sticky hold, set wins over clear
            always @(posedge core_clk_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                begin
                    irq_prev_q[g] <= 1'b0;
                    event_o[g]    <= 1'b0;
                end
                else
                begin
                    irq_prev_q[g] <= ctx_irq_i[g];
                    if (rise[g] | sw_set_i[g])
                        event_o[g] <= 1'b1;
                    else if (sw_clr_i[g])
                        event_o[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### core/iifr_top.v
// Strobed register access was decided locally.
`default_nettype none
`include "iifr_defines.vh"
// Summary of operation
// - eight tx mask bits, set/clear writes
// - tx mask readable at both addresses
// - tx mask bit n gates tx event n
// - four sticky rx context event bits
// - rx event set by edge or write
// - rx event cleared only by clear write
// - rx clear address reads event and mask
// - rx event upper bits read zero
// - rx events feed rx summary event
// - four rx mask bits, set/clear writes
// - rx mask readable at both addresses
// - rx mask bit n gates rx event n
// - eight-bit priority request limit, read/write
// - fairness resets zero, upper bits zero
// - global gate off blocks external interrupt
// - tx events set by edge or write
module iifr_top (
    input  wire                       core_clk_i,
    input  wire                       rst_b_i,
    input  wire [`IIFR_ADDR_W-1:0]    addr_i,
    input  wire [31:0]                wdata_i,
    input  wire                       wr_i,
    input  wire                       rd_i,
    output reg  [31:0]                rdata_o,
    input  wire [`IIFR_TX_CH-1:0]     tx_ctx_irq_i,
    input  wire [`IIFR_RX_CH-1:0]     rx_ctx_irq_i,
    output wire                       tx_iso_summary_event_o,
    output wire                       rx_iso_summary_event_o,
    output wire [`IIFR_RX_CH-1:0]     rx_channel_event_o,
    output wire [`IIFR_PRI_W-1:0]     pri_req_limit_o,
    output wire                       global_irq_gate_o,
    output wire                       irq_o
);
    // ---------------------------------------------------------------
    // register map, byte offsets on addr_i
    // ---------------------------------------------------------------
    // 90 / 94 : tx event set / clear; 94 reads event and mask
    // 98 / 9c : tx mask set / clear; both read the mask
    // a0 / a4 : rx event set / clear; a4 reads event and mask
    // a8 / ac : rx mask set / clear; both read the mask
    // dc      : priority request limit in the low byte
    // f0      : global irq gate in the top bit
    // unmapped offsets read zero and ignore writes;
    // reserved upper bits of every word read zero.
    // event bits are sticky: a rising context line or a
    // set write raises them, only a clear write drops them,
    // and a rise in the same cycle as a clear still wins.
    // read data stand for the one cycle after the strobe.

    // ---------------------------------------------------------------
    // reset synchroniser
    // ---------------------------------------------------------------
    reg rst_meta_q;    // first stage
    reg rst_sync_q;    // released reset used inside

    // two-flop release of asynchronous reset
    // assertion is immediate, release waits two edges;
    // only the second stage is used by the rest of the block
    always @(posedge core_clk_i or negedge rst_b_i)
    begin
        // pin low: both stages cleared at once
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            // shift a one through the pair
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    // one-hot write hit for an offset
    // the strobe is folded in, so a hit lasts one cycle
    function wr_hit;
        input [`IIFR_ADDR_W-1:0] a;
        input [`IIFR_ADDR_W-1:0] off;
        input                    w;
        begin
            wr_hit = w & (a == off);
        end
    endfunction

    // write hits, one per register address
    wire wr_tx_evt_set = wr_hit(addr_i, `IIFR_OFF_TX_EVT_SET, wr_i);
    wire wr_tx_evt_clr = wr_hit(addr_i, `IIFR_OFF_TX_EVT_CLR, wr_i);
    wire wr_tx_msk_set = wr_hit(addr_i, `IIFR_OFF_TX_MSK_SET, wr_i);
    wire wr_tx_msk_clr = wr_hit(addr_i, `IIFR_OFF_TX_MSK_CLR, wr_i);
    wire wr_rx_evt_set = wr_hit(addr_i, `IIFR_OFF_RX_EVT_SET, wr_i);
    wire wr_rx_evt_clr = wr_hit(addr_i, `IIFR_OFF_RX_EVT_CLR, wr_i);
    wire wr_rx_msk_set = wr_hit(addr_i, `IIFR_OFF_RX_MSK_SET, wr_i);
    wire wr_rx_msk_clr = wr_hit(addr_i, `IIFR_OFF_RX_MSK_CLR, wr_i);
    wire wr_fair       = wr_hit(addr_i, `IIFR_OFF_FAIRNESS, wr_i);
    wire wr_main_msk   = wr_hit(addr_i, `IIFR_OFF_MAIN_MSK, wr_i);

    // ---------------------------------------------------------------
    // state registers
    // ---------------------------------------------------------------
    reg  [`IIFR_TX_CH-1:0] tx_mask_q;     // per-channel tx enables
    reg  [`IIFR_RX_CH-1:0] rx_mask_q;     // per-channel rx enables
    reg  [`IIFR_PRI_W-1:0] pri_req_q;     // priority request limit
    reg                    gate_q;        // global irq gate
    wire [`IIFR_TX_CH-1:0] tx_event;      // sticky tx events
    wire [`IIFR_RX_CH-1:0] rx_event;      // sticky rx events
    reg  [`IIFR_TX_CH-1:0] tx_mask_d;     // next tx enables
    reg  [`IIFR_RX_CH-1:0] rx_mask_d;     // next rx enables
    reg  [`IIFR_PRI_W-1:0] pri_req_d;     // next priority limit
    reg                    gate_d;        // next global gate

    // next values of mask and control registers
    // set and clear share one strobe, so they never collide
    always @*
    begin
        // hold every register by default
        tx_mask_d = tx_mask_q;
        rx_mask_d = rx_mask_q;
        pri_req_d = pri_req_q;
        gate_d    = gate_q;
        if (wr_tx_msk_set)
        begin
            // ones set bits, zeros leave them
            tx_mask_d = tx_mask_q | wdata_i[`IIFR_TX_CH-1:0];
        end
        else if (wr_tx_msk_clr)
        begin
            // ones clear bits, zeros leave them
            tx_mask_d = tx_mask_q & ~wdata_i[`IIFR_TX_CH-1:0];
        end
        if (wr_rx_msk_set)
        begin
            // ones set bits, zeros leave them
            rx_mask_d = rx_mask_q | wdata_i[`IIFR_RX_CH-1:0];
        end
        else if (wr_rx_msk_clr)
        begin
            // ones clear bits, zeros leave them
            rx_mask_d = rx_mask_q & ~wdata_i[`IIFR_RX_CH-1:0];
        end
        if (wr_fair)
        begin
            // low byte only, upper bits dropped
            pri_req_d = wdata_i[`IIFR_PRI_W-1:0];
        end
        // gate bit lives in its own register
        if (wr_main_msk)
        begin
            // plain read/write bit, no set/clear pair
            gate_d = wdata_i[`IIFR_GATE_BIT];
        end
    end

    // mask and control registers
    always @(posedge core_clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            // all enables off, limit zero, gate closed
            tx_mask_q <= `IIFR_TX_RST;
            rx_mask_q <= `IIFR_RX_RST;
            pri_req_q <= `IIFR_PRI_RST;
            gate_q    <= 1'b0;
        end
        else
        begin
            // load next values
            tx_mask_q <= tx_mask_d;
            rx_mask_q <= rx_mask_d;
            pri_req_q <= pri_req_d;
            gate_q    <= gate_d;
        end
    end

    // ---------------------------------------------------------------
    // sticky event banks
    // ---------------------------------------------------------------
    // strobes become per-bit pulses; idle value is all zeros
    // a line held high makes one event, not one per cycle
    // tx events by edge or set write
    iifr_event_bits #(
        .N (`IIFR_TX_CH)
    ) u_tx_events (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_sync_q),
        .ctx_irq_i  (tx_ctx_irq_i),
        .sw_set_i   (wr_tx_evt_set ? wdata_i[`IIFR_TX_CH-1:0] : `IIFR_TX_RST),
        .sw_clr_i   (wr_tx_evt_clr ? wdata_i[`IIFR_TX_CH-1:0] : `IIFR_TX_RST),
        .event_o    (tx_event)
    );

    // same bank shape, four receive contexts
    // reads never touch these bits
    // rx events by edge or write
    iifr_event_bits #(
        .N (`IIFR_RX_CH)
    ) u_rx_events (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_sync_q),
        .ctx_irq_i  (rx_ctx_irq_i),
        .sw_set_i   (wr_rx_evt_set ? wdata_i[`IIFR_RX_CH-1:0] : `IIFR_RX_RST),
        .sw_clr_i   (wr_rx_evt_clr ? wdata_i[`IIFR_RX_CH-1:0] : `IIFR_RX_RST),
        .event_o    (rx_event)
    );

    // ---------------------------------------------------------------
    // summary and interrupt
    // ---------------------------------------------------------------
    // masked copies feed the summaries and the clear-address reads
    // tx mask gates tx event
    wire [`IIFR_TX_CH-1:0] tx_masked = tx_event & tx_mask_q;
    wire [`IIFR_RX_CH-1:0] rx_masked = rx_event & rx_mask_q;

    // summaries are plain gates on flop outputs, no extra delay
    // or-reduce masked events
    assign tx_iso_summary_event_o = |tx_masked;
    assign rx_iso_summary_event_o = |rx_masked;
    // raw rx events for the main event logic
    assign rx_channel_event_o     = rx_event;
    // limit for the arbitration logic elsewhere
    assign pri_req_limit_o        = pri_req_q;
    // gate copy for the main interrupt logic
    assign global_irq_gate_o      = gate_q;
    // gate off masks irq_o only; the summaries and the event bits still record
    // gate blocks external interrupt
    assign irq_o = gate_q & (tx_iso_summary_event_o | rx_iso_summary_event_o);

    // ---------------------------------------------------------------
    // read mux, data one cycle after strobe
    // ---------------------------------------------------------------
    reg [31:0] rdata_d;    // selected read word

    // decode read word; unmapped reads zero
    always @*
    begin
        rdata_d = `IIFR_ZERO32;
        case (addr_i)
            // raw tx events
            `IIFR_OFF_TX_EVT_SET:
                rdata_d[`IIFR_TX_CH-1:0] = tx_event;
            // tx events qualified by mask
            `IIFR_OFF_TX_EVT_CLR:
                rdata_d[`IIFR_TX_CH-1:0] = tx_masked;
            `IIFR_OFF_TX_MSK_SET,
            `IIFR_OFF_TX_MSK_CLR:
                rdata_d[`IIFR_TX_CH-1:0] = tx_mask_q;
            `IIFR_OFF_RX_EVT_SET:
                rdata_d[`IIFR_RX_CH-1:0] = rx_event;
            `IIFR_OFF_RX_EVT_CLR:
                rdata_d[`IIFR_RX_CH-1:0] = rx_masked;
            `IIFR_OFF_RX_MSK_SET,
            `IIFR_OFF_RX_MSK_CLR:
                rdata_d[`IIFR_RX_CH-1:0] = rx_mask_q;
            `IIFR_OFF_FAIRNESS:
                rdata_d[`IIFR_PRI_W-1:0] = pri_req_q;
            // gate alone in the top bit
            `IIFR_OFF_MAIN_MSK:
                rdata_d[`IIFR_GATE_BIT] = gate_q;
            // unmapped offsets read zero
            default:
                rdata_d = `IIFR_ZERO32;
        endcase
    end

    // register read data only on a read strobe
    // the word stands one cycle, then the bus rests at zero,
    // so a stale word is never mistaken for a fresh one
    always @(posedge core_clk_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            // bus quiet in reset
            rdata_o <= `IIFR_ZERO32;
        end
        else if (rd_i)
        begin
            // capture the selected word
            rdata_o <= rdata_d;
        end
        else
        begin
            // no read: drive zero
            rdata_o <= `IIFR_ZERO32;
        end
    end
endmodule
`default_nettype wire

// ### tb/iifr_assertions.sv
`default_nettype none
// ---------------------------------------------------------------
// port checker for the register block
// ---------------------------------------------------------------
module iifr_assertions (
    input wire logic        core_clk_i,
    input wire logic        rst_b_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [7:0]  tx_ctx_irq_i,
    input wire logic [3:0]  rx_ctx_irq_i,
    input wire logic        tx_iso_summary_event_o,
    input wire logic        rx_iso_summary_event_o,
    input wire logic [3:0]  rx_channel_event_o,
    input wire logic [7:0]  pri_req_limit_o,
    input wire logic        global_irq_gate_o,
    input wire logic        irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] rx_prev_q;                                        // lines at last edge
    wire  [3:0] rx_rise = rx_ctx_irq_i & ~rx_prev_q;              // new rising edges
    wire  [3:0] rx_clr  = (wr_i && addr_i == 8'ha4) ? wdata_i[3:0] : 4'h0;
    // edge detector history
    always_ff @(posedge core_clk_i or negedge rst_b_i)
        if (!rst_b_i)
            rx_prev_q <= 4'h0;
        else
            rx_prev_q <= rx_ctx_irq_i;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_gate_blocks_irq: assert property (!global_irq_gate_o |-> !irq_o)
        else $error("irq raised while gate off");
    a_irq_from_sum: assert property (
        irq_o |-> global_irq_gate_o && (tx_iso_summary_event_o || rx_iso_summary_event_o))
        else $error("irq without masked event");
    a_rx_edge_sets: assert property (
        (|rx_rise) |=> ((rx_channel_event_o & $past(rx_rise)) == $past(rx_rise)))
        else $error("rx edge did not set event");
    a_rx_event_sticky: assert property (
        (|rx_channel_event_o) |=> ($past(rx_channel_event_o) & ~rx_channel_event_o & ~$past(rx_clr)) == 4'h0)
        else $error("rx event cleared without clear write");
    a_fair_read: assert property (
        rd_i && addr_i == 8'hdc |=> rdata_o == {24'h0, $past(pri_req_limit_o)})
        else $error("fairness read wrong");
    a_rx_event_read: assert property (
        rd_i && addr_i == 8'ha0 |=> rdata_o == {28'h0, $past(rx_channel_event_o)})
        else $error("rx event read wrong");
    a_rx_sum_idle: assert property (rx_channel_event_o == 4'h0 |-> !rx_iso_summary_event_o)
        else $error("rx summary without event");
    a_fair_write: assert property (
        wr_i && addr_i == 8'hdc |=> pri_req_limit_o == $past(wdata_i[7:0]))
        else $error("fairness write lost");
    c_rx_edge: cover property (|rx_rise);
    c_irq: cover property (irq_o);
    c_fair: cover property (wr_i && addr_i == 8'hdc);
endmodule
bind iifr_top iifr_assertions u_chk (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .tx_ctx_irq_i, .rx_ctx_irq_i, .tx_iso_summary_event_o, .rx_iso_summary_event_o,
    .rx_channel_event_o, .pri_req_limit_o, .global_irq_gate_o, .irq_o);
`default_nettype wire

// ### tb/iifr_top_tb.sv
`default_nettype none
module iifr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk_i   = 1'h0;  // core clock
    logic        rst_b_i      = 1'h0;  // reset, active low
    logic [7:0]  addr_i       = 8'h00; // register address
    logic [31:0] wdata_i      = 32'h0; // write data
    logic        wr_i         = 1'h0;  // write strobe
    logic        rd_i         = 1'h0;  // read strobe
    logic [7:0]  tx_ctx_irq_i = 8'h00; // tx context lines
    logic [3:0]  rx_ctx_irq_i = 4'h0;  // rx context lines
    wire  [31:0] rdata_o;
    wire         tx_iso_summary_event_o, rx_iso_summary_event_o, global_irq_gate_o, irq_o;
    wire  [3:0]  rx_channel_event_o;
    wire  [7:0]  pri_req_limit_o;
    int          error_cnt       = 0;
    int          samples_checked = 0;
    logic [7:0]  offs [7] = '{8'h98, 8'h9c, 8'ha0, 8'ha4, 8'ha8, 8'hac, 8'hdc};
    iifr_top uut (.core_clk_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .tx_ctx_irq_i, .rx_ctx_irq_i, .tx_iso_summary_event_o, .rx_iso_summary_event_o,
        .rx_channel_event_o, .pri_req_limit_o, .global_irq_gate_o, .irq_o);
    initial forever #5 core_clk_i = ~core_clk_i;
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        wr_i    <= 1'h1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge core_clk_i);
        wr_i <= 1'h0;
        #1;
    endtask
    // data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        rd_i   <= 1'h1;
        addr_i <= a;
        @(posedge core_clk_i);
        rd_i <= 1'h0;
        #1 chk(rdata_o, e);
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog against a hung bench
    initial
    begin
        repeat (1000) @(posedge core_clk_i);
        error_cnt++;
        stop_test();
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        repeat (3) @(posedge core_clk_i);
        foreach (offs[i])
            reg_rd(offs[i], 32'h0);
        reg_wr(8'h98, 32'hffffffff);
        reg_rd(8'h9c, 32'h000000ff);
        reg_wr(8'h9c, 32'h0000000f);
        reg_wr(8'h9c, 32'h00000000);
        reg_rd(8'h98, 32'h000000f0);
        reg_wr(8'hdc, 32'hffffffa5);
        reg_rd(8'hdc, 32'h000000a5);
        // read word stands one cycle, then zero
        @(posedge core_clk_i);
        #1 chk(rdata_o, 32'h0);
        chk({24'h0, pri_req_limit_o}, 32'ha5);
        reg_wr(8'ha8, 32'hffffffff);
        reg_wr(8'hac, 32'h00000005);
        reg_rd(8'ha8, 32'h0000000a);
        reg_rd(8'hac, 32'h0000000a);
        // rx events by edge; reads leave them set
        @(posedge core_clk_i);
        rx_ctx_irq_i <= 4'h3;
        reg_rd(8'ha0, 32'h00000003);
        reg_rd(8'ha4, 32'h00000002);
        reg_rd(8'ha0, 32'h00000003);
        chk({31'h0, rx_iso_summary_event_o}, 32'h1);
        chk({31'h0, irq_o}, 32'h0);
        reg_wr(8'hf0, 32'h80000000);
        chk({31'h0, global_irq_gate_o}, 32'h1);
        chk({31'h0, irq_o}, 32'h1);
        // clear while lines stay high, then software set
        reg_wr(8'ha4, 32'h0000000f);
        reg_rd(8'ha0, 32'h00000000);
        reg_wr(8'ha0, 32'hfffffff4);
        reg_rd(8'ha0, 32'h00000004);
        reg_rd(8'ha4, 32'h00000000);
        chk({31'h0, irq_o}, 32'h0);
        @(posedge core_clk_i);
        rx_ctx_irq_i <= 4'h0;
        @(posedge core_clk_i);
        rx_ctx_irq_i <= 4'h2;
        reg_rd(8'ha4, 32'h00000002);
        chk({28'h0, rx_channel_event_o}, 32'h6);
        reg_wr(8'ha4, 32'h0000000f);
        chk({31'h0, rx_iso_summary_event_o}, 32'h0);
        // tx events gated by tx mask
        @(posedge core_clk_i);
        tx_ctx_irq_i <= 8'h90;
        repeat (2) @(posedge core_clk_i);
        #1 chk({31'h0, tx_iso_summary_event_o}, 32'h1);
        reg_rd(8'h90, 32'h00000090);
        reg_rd(8'h94, 32'h00000090);
        reg_wr(8'h9c, 32'h00000090);
        chk({31'h0, irq_o}, 32'h0);
        reg_wr(8'h98, 32'h00000010);
        chk({31'h0, irq_o}, 32'h1);
        reg_wr(8'hf0, 32'h00000000);
        chk({31'h0, global_irq_gate_o}, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        // tx software set, then clear while lines stay high
        reg_wr(8'h90, 32'h00000001);
        reg_rd(8'h90, 32'h00000091);
        reg_wr(8'h94, 32'h000000ff);
        reg_rd(8'h90, 32'h00000000);
        chk({31'h0, tx_iso_summary_event_o}, 32'h0);
        reg_wr(8'h40, 32'hffffffff);
        reg_rd(8'h40, 32'h00000000);
        stop_test();
    end
endmodule
`default_nettype wire
